// ==== ssc_serial_ctrl.sv ====
`include "ssc_consts.svh"

module ssc_serial_ctrl (
  // system clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // serial link
  input  wire logic                     ser_clk,
  input  wire logic                     ser_data,
  input  wire logic                     latch_strobe,
  // device pins
  input  wire logic                     chip_en,
  input  wire logic                     pre_in,
  // charge pump, doubler and oscillator
  output ssc_pkg::ssc_pump_t            pump_output,
  output logic [`SSC_R_CP_W-1:0]        pump_current_code,
  output logic                          doubler_on,
  output logic                          osc_enable,
  // lock, swallow and auxiliary pins
  output logic                          lock_status_out,
  output logic                          swallow_pulse,
  output ssc_pkg::ssc_aux_t             aux_out
);

  localparam int LOCK_IN_CYC  = (`SSC_LOCK_IN_NS / `SSC_CLK_PERIOD_NS < 1) ? 1 :
                                `SSC_LOCK_IN_NS / `SSC_CLK_PERIOD_NS;
  localparam int LOCK_OUT_CYC = (`SSC_LOCK_OUT_NS / `SSC_CLK_PERIOD_NS < 1) ? 1 :
                                `SSC_LOCK_OUT_NS / `SSC_CLK_PERIOD_NS;

  // ==========================================================
  // serial shift register, link clock domain
  logic [`SSC_WORD_W-1:0] shift_r;

  always_ff @(posedge ser_clk) begin
    shift_r <= {shift_r[`SSC_WORD_W-2:0], ser_data};
  end

  // ==========================================================
  // input synchronisers
  logic le_s1_r;
  logic le_s2_r;
  logic le_s3_r;
  logic ce_s1_r;
  logic ce_s2_r;
  logic pre_s1_r;
  logic pre_s2_r;
  logic pre_s3_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      le_s1_r  <= 1'b0;
      le_s2_r  <= 1'b0;
      le_s3_r  <= 1'b0;
      ce_s1_r  <= 1'b0;
      ce_s2_r  <= 1'b0;
      pre_s1_r <= 1'b0;
      pre_s2_r <= 1'b0;
      pre_s3_r <= 1'b0;
    end else begin
      le_s1_r  <= latch_strobe;
      le_s2_r  <= le_s1_r;
      le_s3_r  <= le_s2_r;
      ce_s1_r  <= chip_en;
      ce_s2_r  <= ce_s1_r;
      pre_s1_r <= pre_in;
      pre_s2_r <= pre_s1_r;
      pre_s3_r <= pre_s2_r;
    end
  end

  wire le_rise  = le_s2_r & ~le_s3_r;
  wire pre_rise = pre_s2_r & ~pre_s3_r;

  // ==========================================================
  // word decode
  // shift word is static while the strobe is high: link clock is idle
  // strobe after last bit
  wire [`SSC_DATA_W-1:0] word_data = shift_r[`SSC_WORD_W-1:`SSC_DATA_LSB];
  wire [`SSC_ADDR_W-1:0] word_addr = shift_r[`SSC_ADDR_W-1:0];

  // ==========================================================
  // four configuration latches
  logic [`SSC_DATA_W-1:0] cfg_r [0:3];

  for (genvar i = 0; i < 4; i++) begin : g_latch
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        cfg_r[i] <= `SSC_CFG_RESET;
      end else if (le_rise && (word_addr == `SSC_ADDR_W'(i))) begin
        cfg_r[i] <= word_data;
      end
    end
  end

  // ==========================================================
  // field extraction
  wire [`SSC_DATA_W-1:0] f1_w = cfg_r[`SSC_ADDR_FRAC_FIRST];
  wire [`SSC_DATA_W-1:0] f2_w = cfg_r[`SSC_ADDR_FRAC_SECOND];
  wire [`SSC_DATA_W-1:0] rd_w = cfg_r[`SSC_ADDR_REF_DIV];
  wire [`SSC_DATA_W-1:0] nd_w = cfg_r[`SSC_ADDR_FB_DIV];

  wire [`SSC_F1_LOCK_W-1:0] lock_sel     = f1_w[`SSC_F1_LOCK_LSB +: `SSC_F1_LOCK_W];
  wire                      mod_sixteen  = f1_w[`SSC_F1_MOD16_BIT];
  wire [`SSC_F2_AUX_W-1:0]  aux_mode     = f2_w[`SSC_F2_AUX_LSB +: `SSC_F2_AUX_W];
  wire                      sleep_sync_select = f2_w[`SSC_F2_SYNC_BIT];
  wire [`SSC_R_DIV_W-1:0]   ref_divide_value  = rd_w[`SSC_R_DIV_LSB +: `SSC_R_DIV_W];
  wire                      detector_polarity = rd_w[`SSC_R_POL_BIT];
  wire [`SSC_R_CP_W-1:0]    cp_code      = rd_w[`SSC_R_CP_LSB +: `SSC_R_CP_W];
  wire                      doubler_bit  = rd_w[`SSC_R_DOUBLER_BIT];
  wire [`SSC_N_FRAC_W-1:0]  frac_num     = nd_w[`SSC_N_FRAC_LSB +: `SSC_N_FRAC_W];
  wire [`SSC_N_B_W-1:0]     fb_divide    = nd_w[`SSC_N_B_LSB +: `SSC_N_B_W];
  wire                      sleep_bit    = nd_w[`SSC_N_SLEEP_BIT];
  wire                      divider_clear = nd_w[`SSC_N_CLEAR_BIT];

  // ==========================================================
  // power control
  logic up_r;
  logic dn_r;
  logic sleep_r;
  wire  pump_busy = up_r | dn_r;

  wire sleep_req = ~ce_s2_r | sleep_bit;
  wire sleep_nxt = sleep_req & (sleep_r | ~sleep_sync_select | ~pump_busy);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= sleep_nxt;
    end
  end

  // ==========================================================
  // dividers
  // counters held in sleep
  wire cnt_clear = sleep_r | divider_clear;
  wire ref_tick;
  wire fb_tick;

  ssc_divider #(
    .W (`SSC_R_DIV_W)
  ) u_ref_div (
    .clk   (ref_clk),
    .rst   (rst),
    .clear (cnt_clear),
    .step  (1'b1),
    .ratio (ref_divide_value),
    .tick  (ref_tick)
  );

  ssc_divider #(
    .W (`SSC_N_B_W)
  ) u_fb_div (
    .clk   (ref_clk),
    .rst   (rst),
    .clear (cnt_clear),
    .step  (pre_rise),
    .ratio (fb_divide),
    .tick  (fb_tick)
  );

  // ==========================================================
  // fractional accumulator
  logic [`SSC_N_FRAC_W-1:0] acc_r;
  logic                     swallow_r;

  wire [4:0] acc_sum  = {1'b0, acc_r} + {1'b0, frac_num};
  wire [4:0] modulus  = mod_sixteen ? `SSC_MOD_SIXTEEN : `SSC_MOD_FIFTEEN;
  wire       acc_ovf  = (acc_sum >= modulus);
  wire [4:0] acc_wrap = acc_sum - modulus;

  always_ff @(posedge ref_clk) begin
    if (rst || cnt_clear) begin
      acc_r     <= '0;
      swallow_r <= 1'b0;
    end else begin
      swallow_r <= 1'b0;
      if (fb_tick) begin
        acc_r     <= acc_ovf ? acc_wrap[3:0] : acc_sum[3:0];
        swallow_r <= acc_ovf;
      end
    end
  end

  // ==========================================================
  // phase detector
  wire up_set  = up_r | ref_tick;
  wire dn_set  = dn_r | fb_tick;
  wire pd_both = up_set & dn_set;

  always_ff @(posedge ref_clk) begin
    if (rst || sleep_r) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else begin
      up_r <= up_set & ~pd_both;
      dn_r <= dn_set & ~pd_both;
    end
  end

  // ==========================================================
  // digital lock filter
  logic [`SSC_ERR_CNT_W-1:0]  err_r;
  logic [`SSC_GOOD_CNT_W-1:0] good_r;
  logic                       dig_lock_r;
  logic [`SSC_ERR_CNT_W-1:0]  err_nxt;
  logic [`SSC_GOOD_CNT_W-1:0] good_nxt;
  logic                       dig_lock_nxt;

  wire err_full  = &err_r;
  wire err_small = (err_r < `SSC_ERR_CNT_W'(LOCK_IN_CYC));
  wire err_large = (err_r > `SSC_ERR_CNT_W'(LOCK_OUT_CYC));
  wire good_done = (good_r >= `SSC_GOOD_CNT_W'(`SSC_LOCK_GOOD_CYC - 1));

  always_comb begin
    err_nxt      = err_r;
    good_nxt     = good_r;
    dig_lock_nxt = dig_lock_r;
    if (cnt_clear) begin
      err_nxt      = '0;
      good_nxt     = '0;
      dig_lock_nxt = 1'b0;
    end else if (ref_tick) begin
      err_nxt = {{(`SSC_ERR_CNT_W-1){1'b0}}, pump_busy};
      if (err_large) begin
        good_nxt     = '0;
        dig_lock_nxt = 1'b0;
      end else if (err_small) begin
        good_nxt = good_done ? good_r : good_r + `SSC_GOOD_CNT_W'(1);
        if (good_done) begin
          dig_lock_nxt = 1'b1;
        end
      end else begin
        good_nxt = '0;
      end
    end else if (pump_busy && !err_full) begin
      err_nxt = err_r + `SSC_ERR_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_r      <= '0;
      good_r     <= '0;
      dig_lock_r <= 1'b0;
    end else begin
      err_r      <= err_nxt;
      good_r     <= good_nxt;
      dig_lock_r <= dig_lock_nxt;
    end
  end

  // ==========================================================
  // lock output select
  logic lock_nxt;

  always_comb begin
    case (ssc_pkg::ssc_lock_mode_t'(lock_sel))
      ssc_pkg::SSC_LOCK_DIGITAL: lock_nxt = dig_lock_r;
      ssc_pkg::SSC_LOCK_ANALOG:  lock_nxt = ~pump_busy;
      default:                   lock_nxt = 1'b0;
    endcase
    if (sleep_r) begin
      lock_nxt = 1'b0;
    end
  end

  // ==========================================================
  // auxiliary pins and fastlock
  wire test_mode   = aux_mode[`SSC_AUX_TEST_BIT];
  wire fast_mode   = aux_mode[`SSC_AUX_FAST_BIT];
  wire fast_active = fast_mode & ~dig_lock_r & ~sleep_r;

  ssc_pkg::ssc_aux_t aux_nxt;

  always_comb begin
    if (test_mode) begin
      aux_nxt.zero = ref_tick;
      aux_nxt.one  = fb_tick;
    end else if (fast_mode) begin
      aux_nxt.zero = ~fast_active;
      aux_nxt.one  = aux_mode[1];
    end else begin
      aux_nxt.zero = aux_mode[0];
      aux_nxt.one  = aux_mode[1];
    end
  end

  // ==========================================================
  // pump drive
  ssc_pkg::ssc_pump_t pump_nxt;

  always_comb begin
    pump_nxt.up = ~sleep_r & (detector_polarity ? up_r : dn_r);
    pump_nxt.dn = ~sleep_r & (detector_polarity ? dn_r : up_r);
    pump_nxt.oe = ~sleep_r;
  end

  wire [`SSC_R_CP_W-1:0] code_nxt = fast_active ? `SSC_CP_FAST_CODE : cp_code;

  // ==========================================================
  // output registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pump_output       <= '0;
      pump_current_code <= '0;
      doubler_on        <= 1'b0;
      osc_enable        <= 1'b0;
      lock_status_out   <= 1'b0;
      swallow_pulse     <= 1'b0;
      aux_out           <= '0;
    end else begin
      pump_output       <= pump_nxt;
      pump_current_code <= code_nxt;
      doubler_on        <= doubler_bit;
      osc_enable        <= ~sleep_req | doubler_bit;
      lock_status_out   <= lock_nxt;
      swallow_pulse     <= swallow_r;
      aux_out           <= aux_nxt;
    end
  end

endmodule

// ==== ssc_consts.svh ====
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// ==========================================================
// serial word layout
`define SSC_WORD_W          24
`define SSC_DATA_W          22
`define SSC_ADDR_W          2
`define SSC_DATA_LSB        2

// ==========================================================
// latch addresses
`define SSC_ADDR_FRAC_FIRST  2'h0
`define SSC_ADDR_FRAC_SECOND 2'h1
`define SSC_ADDR_REF_DIV     2'h2
`define SSC_ADDR_FB_DIV      2'h3
`define SSC_CFG_RESET        22'h000000

// ==========================================================
// first fractional configuration fields
`define SSC_F1_LOCK_LSB     17
`define SSC_F1_LOCK_W       3
`define SSC_F1_MOD16_BIT    20

// ==========================================================
// second fractional configuration fields
`define SSC_F2_AUX_LSB      15
`define SSC_F2_AUX_W        4
`define SSC_F2_SYNC_BIT     19
`define SSC_AUX_TEST_BIT    3
`define SSC_AUX_FAST_BIT    2

// ==========================================================
// reference divider fields
`define SSC_R_DIV_LSB       0
`define SSC_R_DIV_W         15
`define SSC_R_POL_BIT       15
`define SSC_R_CP_LSB        16
`define SSC_R_CP_W          4
`define SSC_R_DOUBLER_BIT   20

// ==========================================================
// feedback divider fields
`define SSC_N_FRAC_LSB      0
`define SSC_N_FRAC_W        4
`define SSC_N_B_LSB         9
`define SSC_N_B_W           10
`define SSC_N_SLEEP_BIT     20
`define SSC_N_CLEAR_BIT     21

// ==========================================================
// fractional moduli and pump codes
`define SSC_MOD_SIXTEEN     5'h10
`define SSC_MOD_FIFTEEN     5'h0F
`define SSC_CP_FAST_CODE    4'hF

// ==========================================================
// timing
`define SSC_CLK_PERIOD_NS   40
`define SSC_LOCK_IN_NS      15
`define SSC_LOCK_OUT_NS     30
`define SSC_LOCK_GOOD_CYC   5
`define SSC_ERR_CNT_W       4
`define SSC_GOOD_CNT_W      3

`endif

// ==== ssc_pkg.sv ====
package ssc_pkg;

  // ==========================================================
  // lock output selection
  typedef enum logic [2:0] {
    SSC_LOCK_OFF     = 3'h0,
    SSC_LOCK_DIGITAL = 3'h1,
    SSC_LOCK_ANALOG  = 3'h2
  } ssc_lock_mode_t;

  // ==========================================================
  // charge pump drive group
  typedef struct packed {
    logic up;
    logic dn;
    logic oe;
  } ssc_pump_t;

  // ==========================================================
  // auxiliary pin pair
  typedef struct packed {
    logic one;
    logic zero;
  } ssc_aux_t;

endpackage

// ==== ssc_divider.sv ====
`include "ssc_consts.svh"

module ssc_divider #(
  parameter int W = 15
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic         clear,
  input  wire logic         step,
  input  wire logic [W-1:0] ratio,
  // terminal count
  output logic              tick
);

  // ==========================================================
  // elaboration check
  if (W < 2) begin : g_bad_width
    $error("ssc_divider width too small");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_nxt;
  wire          at_end = (cnt_r == ratio - W'(1));

  // ==========================================================
  // count steps and wrap on ratio
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (clear) begin
      cnt_nxt = '0;
    end else if (step && at_end) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else if (step) begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule

// ==== ssc_serial_ctrl_checker.sv ====
module ssc_serial_ctrl_checker (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               rst,
  // pins
  input wire logic               latch_strobe,
  input wire logic               chip_en,
  // outputs watched
  input wire ssc_pkg::ssc_pump_t pump_output,
  input wire logic               doubler_on,
  input wire logic               osc_enable,
  input wire logic               lock_status_out,
  input wire logic               swallow_pulse
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_RST_QUIET: assert property ($fell(rst) |-> pump_output == 3'h0 && !lock_status_out && !swallow_pulse)
    else $error("outputs not quiet after reset");
  AST_PUMP_FLOAT: assert property (!pump_output.oe |-> !pump_output.up && !pump_output.dn)
    else $error("pump driven while floating");
  AST_LOCK_ASLEEP: assert property (!pump_output.oe |-> !lock_status_out)
    else $error("lock high while powered down");
  AST_WAKE_LOCK: assert property ($rose(pump_output.oe) |-> !lock_status_out)
    else $error("lock high at wake");
  AST_CE_OVERRIDE: assert property ((!chip_en && $stable(doubler_on)) [*6] |-> osc_enable == doubler_on)
    else $error("enable pin low did not force power down");
  AST_DOUBLER_OSC: assert property (doubler_on && $past(doubler_on) |-> osc_enable)
    else $error("oscillator off with doubler on");
  AST_LATCH_CAUSE: assert property ($changed(doubler_on) |->
      $past(latch_strobe, 3) || $past(latch_strobe, 4) || $past(latch_strobe, 5))
    else $error("doubler changed without strobe");
  AST_SWALLOW_SINGLE: assert property (swallow_pulse |=> !swallow_pulse)
    else $error("swallow pulse longer than one cycle");
  AST_PUMP_BOTH: assert property (!(pump_output.up && pump_output.dn))
    else $error("pump up and down driven together");
endmodule

// ==== ssc_host_model.sv ====
module ssc_host_model (
  // serial link
  output logic ser_clk,
  output logic ser_data,
  output logic latch_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    latch_strobe = 1'b0;
  end

  // ==========================================================
  // one word, clock stopped outside the frame
  task automatic send_word(input logic [23:0] w);
    int i;
    for (i = 23; i >= 0; i--) begin
      ser_data = w[i];
      #24 ser_clk = 1'b1;
      #24 ser_clk = 1'b0;
    end
    ser_data = ~w[0];
    #48 latch_strobe = 1'b1;
    #320 latch_strobe = 1'b0;
    #160;
  endtask
endmodule

// ==== test_synth_serial_control_logic.sv ====
module test_synth_serial_control_logic;
  timeunit 1ns;
  timeprecision 100ps;

  logic               ref_clk, rst, chip_en, pre_in, pre_run;
  logic               ser_clk, ser_data, latch_strobe;
  ssc_pkg::ssc_pump_t pump_output;
  logic [3:0]         pump_current_code;
  logic               doubler_on, osc_enable, lock_status_out, swallow_pulse;
  ssc_pkg::ssc_aux_t  aux_out;
  int                 err_count, n_checks, c;

  ssc_host_model host (.ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe));

  ssc_serial_ctrl dut (
    .ref_clk(ref_clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe),
    .chip_en(chip_en), .pre_in(pre_in), .pump_output(pump_output), .pump_current_code(pump_current_code),
    .doubler_on(doubler_on), .osc_enable(osc_enable), .lock_status_out(lock_status_out),
    .swallow_pulse(swallow_pulse), .aux_out(aux_out)
  );

  // ==========================================================
  // clock, prescaler stand-in, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) pre_in <= pre_run ? ~pre_in : 1'b0;
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end

  // ==========================================================
  // helpers
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic put(input logic [23:0] w);
    host.send_word(w);
    cyc(3);
  endtask
  task automatic count_hi(input logic sel, input int n, output int k);
    k = 0;
    repeat (n) begin
      cyc(1);
      if (sel ? aux_out.zero === 1'b1 : swallow_pulse === 1'b1) k++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_ref_power();
    put(24'h001823);
    put(24'h56001A);
    check("doubler", doubler_on, 8'h01);
    check("code", pump_current_code, 8'h05);
    @(posedge ref_clk) chip_en <= 1'b0;
    cyc(8);
    check("osc_on", osc_enable, 8'h01);
    check("pump_oe", pump_output.oe, 8'h00);
    check("lock_low", lock_status_out, 8'h00);
    put(24'h16001A);
    check("doubler_sleep", doubler_on, 8'h00);
    check("osc_off", osc_enable, 8'h00);
    @(posedge ref_clk) chip_en <= 1'b1;
    cyc(8);
    check("osc_wake", osc_enable, 8'h01);
    check("pump_wake", pump_output.oe, 8'h01);
  endtask

  task automatic sc_addr_sleep();
    put(24'h401823);
    check("sleep_oe", pump_output.oe, 8'h00);
    check("ref_kept", pump_current_code, 8'h05);
    put(24'h001823);
    check("wake_oe", pump_output.oe, 8'h01);
    put(24'h060001);
    check("gpo", aux_out, 8'h03);
  endtask

  task automatic sc_fastlock();
    put(24'h480000);
    put(24'h080001);
    check("fast_aux", aux_out, 8'h00);
    check("fast_code", pump_current_code, 8'h0F);
    check("no_lock", lock_status_out, 8'h00);
    put(24'h060001);
    check("code_back", pump_current_code, 8'h05);
  endtask

  task automatic sc_swallow();
    @(posedge ref_clk) pre_run <= 1'b1;
    cyc(40);
    count_hi(1'b0, 96, c);
    check("swallow16", c[7:0], 8'h08);
    put(24'h000000);
    put(24'h001817);
    cyc(40);
    count_hi(1'b0, 90, c);
    check("swallow15", c[7:0], 8'h05);
    put(24'h100001);
    cyc(10);
    count_hi(1'b1, 60, c);
    check("test_aux", c[7:0], 8'h0A);
    @(posedge ref_clk) pre_run <= 1'b0;
  endtask

  task automatic sc_lock();
    int k;
    put(24'h080000);
    put(24'h801803);
    put(24'h001803);
    for (k = 0; k < 8 && aux_out.zero !== 1'b1; k++) begin
      cyc(1);
    end
    if (aux_out.zero !== 1'b1) begin
      err_count++;
      end_sim();
    end
    repeat (2) @(posedge ref_clk);
    @(posedge ref_clk) pre_run <= 1'b1;
    cyc(42);
    check("lock_early", lock_status_out, 8'h00);
    cyc(5);
    check("lock_dig", lock_status_out, 8'h01);
    put(24'h100000);
    check("lock_ana", lock_status_out, 8'h01);
    @(posedge ref_clk) pre_run <= 1'b0;
    cyc(20);
    check("lock_ana_off", lock_status_out, 8'h00);
    check("pump_pos", pump_output, 8'h05);
    put(24'h080000);
    check("lock_drop", lock_status_out, 8'h00);
    put(24'h14001A);
    check("pump_neg", pump_output, 8'h03);
    put(24'h300001);
    put(24'h401803);
    check("sync_wait", pump_output.oe, 8'h01);
    @(posedge ref_clk) pre_run <= 1'b1;
    cyc(24);
    check("sync_sleep", pump_output.oe, 8'h00);
    @(posedge ref_clk) pre_run <= 1'b0;
    put(24'h001803);
    check("sync_wake", pump_output.oe, 8'h01);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    chip_en = 1'b1;
    pre_run = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(4);
    sc_ref_power();
    sc_addr_sleep();
    sc_fastlock();
    sc_swallow();
    sc_lock();
    end_sim();
  end
endmodule

bind ssc_serial_ctrl ssc_serial_ctrl_checker chk (
  .ref_clk(ref_clk), .rst(rst), .latch_strobe(latch_strobe), .chip_en(chip_en), .pump_output(pump_output),
  .doubler_on(doubler_on), .osc_enable(osc_enable), .lock_status_out(lock_status_out),
  .swallow_pulse(swallow_pulse)
);
